// >>> hdl/sdp_pkg.sv
// constants, field layout and state carriers for the memory-controller parameter register
package sdp_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] PARAM_OFFSET = 16'h0040;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int REMAP_BIT = 0;
  localparam int PWRDN_BIT = 1;
  localparam int EXITLP_BIT = 2;
  localparam int CAPSEL_BIT = 3;
  localparam int COARSE_LSB = 4;
  localparam int FINE_LSB = 8;
  localparam int CNT_W = 4;
  localparam int FIELD_W = 12;
  localparam logic [DATA_W-1:0] WRITE_MASK = 32'h0000_0FFF;

  // ------------------------------------------------------------
  // reset values and delay figures
  // ------------------------------------------------------------
  localparam logic RESET_BIT = 1'h0;
  localparam logic [CNT_W-1:0] RESET_CNT = 4'h0;
  localparam logic CAPSEL_DELAYED = 1'h0;
  localparam logic CAPSEL_FEEDBACK = 1'h1;
  localparam real COARSE_STEP_NS = 0.4;
  localparam real FINE_STEP_NS = 0.1;
  localparam int TAPS = 15;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic remap;
    logic powerDown;
    logic exitLowPower;
    logic captureSel;
    logic [CNT_W-1:0] coarse;
    logic [CNT_W-1:0] fine;
  } sdp_fields_s;

  typedef struct packed {
    sdp_fields_s fields;
    logic [TAPS-1:0] coarseEn;
    logic [TAPS-1:0] fineEn;
    logic [DATA_W-1:0] rdData;
    logic rdValid;
  } sdp_state_s;

  // count of enabled elements to a thermometer enable vector
  function automatic logic [TAPS-1:0] therm(input logic [CNT_W-1:0] count);
    logic [TAPS-1:0] v;
    v = '0;
    for (int i = 0; i < TAPS; i++) begin
      v[i] = (i < int'(count));
    end
    return v;
  endfunction

  // packs the fields into the bus word, reserved bits zero
  function automatic logic [DATA_W-1:0] pack_word(input sdp_fields_s f);
    logic [DATA_W-1:0] w;
    w = '0;
    w[REMAP_BIT] = f.remap;
    w[PWRDN_BIT] = f.powerDown;
    w[EXITLP_BIT] = f.exitLowPower;
    w[CAPSEL_BIT] = f.captureSel;
    w[COARSE_LSB +: CNT_W] = f.coarse;
    w[FINE_LSB +: CNT_W] = f.fine;
    return w;
  endfunction

endpackage

// >>> hdl/sdp_tap_decode.sv
// decoder from element count to delay-line element enables
`timescale 1ns/1ps
module sdp_tap_decode #(
  parameter int TAPS = 15
) (
  input wire logic [sdp_pkg::CNT_W-1:0] count,
  output logic [TAPS-1:0] enables
);

  // ------------------------------------------------------------
  // thermometer code
  // ------------------------------------------------------------
  // thermometer keeps elements chained from the input end, no gaps
  always_comb begin
    enables = sdp_pkg::therm(count);
  end

endmodule

// >>> hdl/sdp_param_reg.sv
// parameter register driving the memory controller core and its clock delay line
`timescale 1ns/1ps
module sdp_param_reg (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic warmRst,
  input wire logic regSel,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [sdp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [sdp_pkg::DATA_W-1:0] regWrData,
  output logic [sdp_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid,
  output logic memRemap,
  output logic memPowerDown,
  output logic exitLowPowerRequest,
  output logic captureClkSel,
  output logic [sdp_pkg::CNT_W-1:0] coarseCount,
  output logic [sdp_pkg::CNT_W-1:0] fineCount,
  output logic [sdp_pkg::TAPS-1:0] coarseTapEn,
  output logic [sdp_pkg::TAPS-1:0] fineTapEn
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sdp_pkg::sdp_state_s state_q;
  sdp_pkg::sdp_state_s state_d;
  sdp_pkg::sdp_fields_s fieldsNext;
  logic [sdp_pkg::TAPS-1:0] coarseDec;
  logic [sdp_pkg::TAPS-1:0] fineDec;
  logic hit;
  logic [sdp_pkg::DATA_W-1:0] wrMasked;

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  assign hit = regSel && (regAddr == sdp_pkg::PARAM_OFFSET);
  assign wrMasked = regWrData & sdp_pkg::WRITE_MASK;

  always_comb begin
    fieldsNext = state_q.fields;
    if (hit && regWr) begin
      fieldsNext.remap = wrMasked[sdp_pkg::REMAP_BIT];
      fieldsNext.powerDown = wrMasked[sdp_pkg::PWRDN_BIT];
      fieldsNext.exitLowPower = wrMasked[sdp_pkg::EXITLP_BIT];
      fieldsNext.captureSel = wrMasked[sdp_pkg::CAPSEL_BIT];
      fieldsNext.coarse = wrMasked[sdp_pkg::COARSE_LSB +: sdp_pkg::CNT_W];
      fieldsNext.fine = wrMasked[sdp_pkg::FINE_LSB +: sdp_pkg::CNT_W];
    end
  end

  // ------------------------------------------------------------
  // delay line enables
  // ------------------------------------------------------------
  // decoded from the next value so enables move in step with the count
  sdp_tap_decode #(
    .TAPS(sdp_pkg::TAPS)
  ) u_coarse (
    .count(fieldsNext.coarse),
    .enables(coarseDec)
  );

  sdp_tap_decode #(
    .TAPS(sdp_pkg::TAPS)
  ) u_fine (
    .count(fieldsNext.fine),
    .enables(fineDec)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.fields = fieldsNext;
    state_d.coarseEn = coarseDec;
    state_d.fineEn = fineDec;
    state_d.rdValid = 1'h0;
    if (regSel && regRd) begin
      // unmapped offsets answer zero so software never reads stale data
      state_d.rdData = hit ? sdp_pkg::pack_word(state_q.fields) : '0;
      state_d.rdValid = 1'h1;
    end
    if (warmRst) begin
      // warm reset drops a pending answer and any write, never clears the fields
      state_d.rdValid = 1'h0;
      state_d.fields = state_q.fields;
      state_d.rdData = state_q.rdData;
      state_d.coarseEn = state_q.coarseEn;
      state_d.fineEn = state_q.fineEn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q.fields.remap <= sdp_pkg::RESET_BIT;
      state_q.fields.powerDown <= sdp_pkg::RESET_BIT;
      state_q.fields.exitLowPower <= sdp_pkg::RESET_BIT;
      state_q.fields.captureSel <= sdp_pkg::CAPSEL_DELAYED;
      state_q.fields.coarse <= sdp_pkg::RESET_CNT;
      state_q.fields.fine <= sdp_pkg::RESET_CNT;
      state_q.coarseEn <= '0;
      state_q.fineEn <= '0;
      state_q.rdData <= '0;
      state_q.rdValid <= 1'h0;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // level outputs straight from the field flops, no extra pipeline
  assign memRemap = state_q.fields.remap;
  assign memPowerDown = state_q.fields.powerDown;
  assign exitLowPowerRequest = state_q.fields.exitLowPower;
  assign captureClkSel = state_q.fields.captureSel;
  assign coarseCount = state_q.fields.coarse;
  assign fineCount = state_q.fields.fine;
  assign coarseTapEn = state_q.coarseEn;
  assign fineTapEn = state_q.fineEn;
  assign regRdData = state_q.rdData;
  assign regRdValid = state_q.rdValid;

endmodule

// >>> test/sdp_param_reg_asserts.sv
// port checker for the parameter register
`timescale 1ns/1ps
module sdp_param_reg_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic warmRst,
  input wire logic regSel,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid,
  input wire logic memRemap,
  input wire logic memPowerDown,
  input wire logic exitLowPowerRequest,
  input wire logic captureClkSel,
  input wire logic [3:0] coarseCount,
  input wire logic [3:0] fineCount,
  input wire logic [14:0] coarseTapEn,
  input wire logic [14:0] fineTapEn
);
  wire logic [11:0] flds = {fineCount, coarseCount, captureClkSel, exitLowPowerRequest, memPowerDown, memRemap};
  wire logic ac = regSel && !warmRst;
  wire logic hit = regAddr == 16'h0040;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // assertions
  // ------------------------------
  a_field_write: assert property (ac && regWr && hit |=> flds == $past(regWrData[11:0]))
    else $error("bad write");
  a_field_hold: assert property (!(ac && regWr && hit) |=> $stable(flds))
    else $error("fields moved");
  a_coarse_therm: assert property (coarseTapEn == 15'h7FFF >> (4'hF - coarseCount))
    else $error("bad coarse taps");
  a_fine_therm: assert property (fineTapEn == 15'h7FFF >> (4'hF - fineCount))
    else $error("bad fine taps");
  a_read_data: assert property (ac && regRd |=> regRdValid && regRdData == ($past(hit) ? {20'h0, $past(flds)} : 32'h0))
    else $error("bad read");
  a_warm_read: assert property (warmRst |=> !regRdValid)
    else $error("read during warm reset");
  a_upper_zero: assert property (regRdValid |-> regRdData[31:12] == 20'h0)
    else $error("reserved bits set");
  a_cold_clear: assert property (disable iff (1'b0) sys_rst |=> flds == 12'h0 && !regRdValid)
    else $error("cold reset missed");
  c_write: cover property (ac && regWr && hit && regWrData[11:0] == 12'hFFF);
  c_read: cover property (ac && regRd && hit);
  c_warm: cover property (warmRst && regSel && regWr);
endmodule
bind sdp_param_reg sdp_param_reg_asserts chk_u (.ref_clk, .sys_rst, .warmRst, .regSel, .regWr, .regRd, .regAddr,
  .regWrData, .regRdData, .regRdValid, .memRemap, .memPowerDown, .exitLowPowerRequest, .captureClkSel,
  .coarseCount, .fineCount, .coarseTapEn, .fineTapEn);

// >>> test/sdp_mem_model.sv
// delay line and capture mux stand-in
`timescale 1ns/1ps
module sdp_mem_model (
  input wire logic [14:0] coarseTapEn,
  input wire logic [14:0] fineTapEn,
  input wire logic captureClkSel,
  output int delayPs
);
  // feedback pin delay is board dependent, shown as zero
  always_comb delayPs = captureClkSel ? 0 : 400 * $countones(coarseTapEn) + 100 * $countones(fineTapEn);
endmodule

// >>> test/sdp_param_reg_tb_top.sv
// self-checking bench for the parameter register
`timescale 1ns/1ps
module sdp_param_reg_tb_top;
  logic ref_clk = 1'h0, sys_rst = 1'h1, warmRst = 1'h0, regSel = 1'h0, regWr = 1'h0, regRd = 1'h0;
  logic [15:0] regAddr = 16'h0;
  logic [31:0] regWrData = 32'h0, regRdData, d;
  logic regRdValid, mR, mP, mE, cS;
  logic [3:0] cC, fC;
  logic [14:0] cT, fT;
  logic [11:0] sh = 12'h0;
  logic [31:0] q[$];
  int error_cnt = 0, checks = 0, delayPs;
  sdp_param_reg dut_u (.ref_clk, .sys_rst, .warmRst, .regSel, .regWr, .regRd, .regAddr, .regWrData, .regRdData,
    .regRdValid, .memRemap(mR), .memPowerDown(mP), .exitLowPowerRequest(mE), .captureClkSel(cS),
    .coarseCount(cC), .fineCount(fC), .coarseTapEn(cT), .fineTapEn(fT));
  sdp_mem_model mdl_u (.coarseTapEn(cT), .fineTapEn(fT), .captureClkSel(cS), .delayPs);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (q.size() != 0) begin
      error_cnt++;
      $display("Error %0t: %0d reads never answered", $time, q.size());
    end
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // expected read word noted at request time, taken off when the answer shows
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] v);
    @(negedge ref_clk);
    {regSel, regWr, regRd, regAddr, regWrData} = {1'h1, w, !w, a, v};
    if (!w && !warmRst) q.push_back(a == 16'h0040 ? {20'h0, sh} : 32'h0);
    else if (w && a == 16'h0040 && !warmRst) sh = v[11:0];
    @(negedge ref_clk);
    {regSel, regWr, regRd} = 3'h0;
  endtask
  always @(negedge ref_clk) if (regRdValid === 1'h1) chk(regRdData, q.size() ? q.pop_front() : 32'hX);
  initial begin
    #200us;
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(69507));
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'h0;
    acc(1'h0, 16'h0040, 32'h0);
    for (int i = 0; i < 12; i++) begin
      d = i ? $urandom : 32'hFFFF_FFFF;
      acc(1'h1, 16'h0040, d);
      chk(delayPs, d[3] ? 32'h0 : 400 * d[7:4] + 100 * d[11:8]);
      chk({20'h0, fC, cC, cS, mE, mP, mR}, {20'h0, d[11:0]});
      chk({17'h0, cT}, (32'h1 << d[7:4]) - 32'h1);
      chk({17'h0, fT}, (32'h1 << d[11:8]) - 32'h1);
      acc(1'h0, 16'h0040, 32'h0);
    end
    acc(1'h1, 16'h0044, ~d);
    acc(1'h0, 16'h0044, 32'h0);
    acc(1'h0, 16'h0040, 32'h0);
    warmRst = 1'h1;
    acc(1'h1, 16'h0040, ~d);
    chk({20'h0, fC, cC, cS, mE, mP, mR}, {20'h0, sh});
    acc(1'h0, 16'h0040, 32'h0);
    warmRst = 1'h0;
    acc(1'h0, 16'h0040, 32'h0);
    sys_rst = 1'h1;
    @(negedge ref_clk);
    sys_rst = 1'h0;
    sh = 12'h0;
    chk({20'h0, fC, cC, cS, mE, mP, mR}, 32'h0);
    chk({fT, cT, 2'h0}, 32'h0);
    acc(1'h0, 16'h0040, 32'h0);
    @(negedge ref_clk);
    results();
  end
endmodule
